//--- adc_front_model.sv
// Behavioural analog front end: converter clock and integrator
module adc_front_model (
  input wire logic pclk,
  input wire logic sw_input,
  input wire logic sw_ref_pos,
  input wire logic sw_ref_neg,
  input wire logic sw_autozero,
  input var int vin,
  output logic conv_clk,
  output logic comp_pos
);
  timeunit 1ns;
  timeprecision 1ns;
  int div_q = 0; // Phase within one converter period
  int integ_q = 0; // Integrator charge, one count per 1000
  initial conv_clk = 1'b0;
  // Free-running oscillator, four pclk per period
  always @(posedge pclk) begin
    div_q <= (div_q + 1) % 4;
    conv_clk <= div_q >= 1 && div_q < 3;
  end
  // Input ramps away, reference of opposite sign ramps back
  always @(posedge conv_clk) begin
    if (sw_autozero) begin
      integ_q <= 0;
    end else if (sw_input) begin
      integ_q <= integ_q + vin;
    end else if (sw_ref_neg) begin
      integ_q <= integ_q - 1000;
    end else if (sw_ref_pos) begin
      integ_q <= integ_q + 1000;
    end
  end
  // Comparator high while integrator sits above rest
  assign comp_pos = integ_q > 0;
endmodule

//--- adc_seq_latch.sv
// Result latch memory: holds the decimal result and flags between ends
module adc_seq_latch (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);

  // Output register loaded only on conversion end; reset shows blank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 16'h5000; // Thousands off, sign low, no overrange
    end else if (load) begin
      rdata <= wdata;
    end
  end

endmodule

//--- adc_seq_pkg.sv
// Package of constants and types for the dual-slope converter sequencer
package adc_seq_pkg;

  // ********************************************************************
  // Register map (APB byte addresses)
  // ********************************************************************
  localparam logic [7:0] ctrl_addr = 8'h00;   // Start and override control
  localparam logic [7:0] status_addr = 8'h04; // Busy, phase, flags
  localparam logic [7:0] result_addr = 8'h08; // Latched decimal result
  localparam logic [7:0] count_addr = 8'h0C;  // Live clock count

  // Control register bit positions
  localparam int ctrl_start_bit = 0;    // Start/reset level
  localparam int ctrl_override_bit = 1; // Counter override level

  // Status register bit positions
  localparam int st_busy_bit = 0;
  localparam int st_ref_bit = 1;
  localparam int st_sign_bit = 2;
  localparam int st_over_n_bit = 3;
  localparam int st_thou_n_bit = 4;

  // Result register field layout
  localparam int res_thou_n_bit = 12;
  localparam int res_sign_bit = 13;
  localparam int res_over_n_bit = 14;

  // ********************************************************************
  // Conversion timing
  // ********************************************************************
  localparam logic [11:0] signal_counts = 12'h3E8; // 1000 clocks
  localparam logic [11:0] over_counts = 12'h7D0;   // 2000 clocks
  localparam logic [11:0] cycle_max = 12'hBB8;     // 3000 clocks
  localparam logic [11:0] count_zero = 12'h000;
  localparam logic [11:0] count_one = 12'h001;
  localparam logic [3:0] bcd_nine = 4'h9;
  localparam logic [3:0] bcd_zero = 4'h0;
  localparam logic [3:0] bcd_one = 4'h1;

  // Least start pulse width and its count at 20 MHz
  localparam int start_min_ns = 100;
  localparam int clk_period_ns = 50;
  localparam int start_min_cycles =
    (start_min_ns + clk_period_ns - 1) / clk_period_ns;

  // Sequencer phases
  typedef enum logic [1:0] {
    ph_autozero = 2'b00,
    ph_signal = 2'b01,
    ph_reference = 2'b10
  } phase_t;

endpackage

//--- adc_seq_top.sv
// Sequencer of a dual-slope converter with APB control and status
// What this block does
// - Start rising edge clears logic, starts conversion
// - After 1000 clocks latch sign, start reference
// - Reference switch chosen by stored sign
// - Zero crossing stops clock, loads latches
// - After end, auto-zero until next start
// - 2000 counts sets overrange, resets sequence
// - Latched outputs change only at conversion end
// - Override high suppresses internal end carry
// - Override high: external count ends signal
// - Busy high while integrating, falls at end
// - Reference output high only in reference
// - Overrange latched active low above 2000
// - Digits active high, thousands active low
// - Sign high for positive input
// - Clock gated during auto-zero, runs in measure
// - Without override, whole measurement takes at most 3000 clocks; under override the signal phase has no cap
// - Gated clock low in auto-zero, else follows
module adc_seq_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_clk,
  input wire logic start_pin,
  input wire logic override_pin,
  input wire logic ext_count_pin,
  input wire logic comp_pos,
  output logic sw_input,
  output logic sw_ref_pos,
  output logic sw_ref_neg,
  output logic sw_autozero,
  output logic busy,
  output logic ref_phase,
  output logic gated_clk,
  output logic sign_out,
  output logic overrange_flag_n,
  output logic thou_n,
  output logic [11:0] digits
);

  // ********************************************************************
  // Input synchronisers
  // ********************************************************************
  logic [4:0] sync1_q; // First stage, read only by second stage
  logic [4:0] sync2_q; // Second stage, safe to use
  logic cclk_q;        // Previous synced conversion clock
  logic start_q;       // Previous combined start level
  logic ext_q;         // Previous synced external count

  // Two flops on every pin from outside the clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {comp_pos, ext_count_pin, override_pin, start_pin,
                  conv_clk};
      sync2_q <= sync1_q;
    end
  end

  logic cclk_s;
  logic start_s;
  logic ovr_s;
  logic ext_s;
  logic comp_s;
  assign cclk_s = sync2_q[0];
  assign start_s = sync2_q[1];
  assign ovr_s = sync2_q[2];
  assign ext_s = sync2_q[3];
  assign comp_s = sync2_q[4];

  // ********************************************************************
  // Register bus
  // ********************************************************************
  logic start_reg_q;    // Software start/reset level
  logic override_reg_q; // Software override level
  logic wr_en;
  logic rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  // Control register writes; zero-wait transfers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg_q <= 1'b0;
      override_reg_q <= 1'b0;
    end else if (wr_en && paddr == adc_seq_pkg::ctrl_addr) begin
      start_reg_q <= pwdata[adc_seq_pkg::ctrl_start_bit];
      override_reg_q <= pwdata[adc_seq_pkg::ctrl_override_bit];
    end
  end

  logic start_lvl;
  logic ovr_lvl;
  // Pin and register are ORed so either party can drive the sequence
  assign start_lvl = start_s | start_reg_q;
  assign ovr_lvl = ovr_s | override_reg_q;

  // ********************************************************************
  // Edge detection and clock tick
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cclk_q <= 1'b0;
      start_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      cclk_q <= cclk_s;
      start_q <= start_lvl;
      ext_q <= ext_s;
    end
  end

  logic start_rise;
  logic tick;     // One-cycle enable per conversion clock rising edge
  logic ext_rise;
  assign start_rise = start_lvl && !start_q;
  assign tick = cclk_s && !cclk_q;
  assign ext_rise = ext_s && !ext_q;

  // ********************************************************************
  // Sequencer
  // ********************************************************************
  adc_seq_pkg::phase_t phase_q;
  logic [11:0] count_q;   // Clocks counted in the current phase
  logic [11:0] total_q;   // Clocks counted in the whole measurement
  logic [3:0] bcd_q [3];  // Live decimal counter, units first
  logic thou_q;           // Live thousands digit
  logic sign_q;           // Stored polarity, high for positive
  logic done;             // Conversion complete, one cycle
  logic overflow;         // Overrange detected, one cycle

  // Decimal increment of one digit with carry out
  function automatic logic [4:0] bcd_inc(input logic [3:0] d,
                                         input logic cin);
    if (!cin) begin
      bcd_inc = {1'b0, d};
    end else if (d == adc_seq_pkg::bcd_nine) begin
      bcd_inc = {1'b1, adc_seq_pkg::bcd_zero};
    end else begin
      bcd_inc = {1'b0, d + adc_seq_pkg::bcd_one};
    end
  endfunction

  logic carry_int; // Internal carry ending signal integrate
  logic sig_end;
  assign carry_int = (count_q == adc_seq_pkg::signal_counts - 
                      adc_seq_pkg::count_one) && tick;
  // Override blocks carry and hands the transition to external count
  assign sig_end = ovr_lvl ? ext_rise : carry_int;
  // Zero crossing: integrator back past rest point, shown by comparator
  assign done = (phase_q == adc_seq_pkg::ph_reference) && tick &&
                (comp_s != sign_q);
  // Overrange at 2000 reference counts or the 3000-clock cap
  assign overflow = (phase_q == adc_seq_pkg::ph_reference) && tick &&
                    !done &&
                    ((count_q == adc_seq_pkg::over_counts) ||
                     (total_q >= adc_seq_pkg::cycle_max));

  // Phase sequencing; a start edge always restarts from signal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= adc_seq_pkg::ph_autozero;
    end else if (start_rise) begin
      phase_q <= adc_seq_pkg::ph_signal;
    end else begin
      case (phase_q)
        adc_seq_pkg::ph_signal: begin
          if (sig_end) begin
            phase_q <= adc_seq_pkg::ph_reference;
          end
        end
        adc_seq_pkg::ph_reference: begin
          if (done || overflow) begin
            phase_q <= adc_seq_pkg::ph_autozero;
          end
        end
        default: begin
          phase_q <= adc_seq_pkg::ph_autozero; // Wait for start
        end
      endcase
    end
  end

  // Sign taken from comparator as the signal phase ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sign_q <= 1'b0;
    end else if (start_rise) begin
      sign_q <= 1'b0;
    end else if (phase_q == adc_seq_pkg::ph_signal && sig_end) begin
      sign_q <= comp_s;
    end
  end

  // Phase counter; counts on clock ticks and on the signal end, gated off in auto-zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= adc_seq_pkg::count_zero;
      total_q <= adc_seq_pkg::count_zero;
    end else if (start_rise) begin
      count_q <= adc_seq_pkg::count_zero;
      total_q <= adc_seq_pkg::count_zero;
    end else if (phase_q == adc_seq_pkg::ph_signal && sig_end) begin
      count_q <= adc_seq_pkg::count_zero;
      total_q <= total_q + adc_seq_pkg::count_one;
    end else if (phase_q != adc_seq_pkg::ph_autozero && tick) begin
      // Wraps under override so the external logic can count N carries
      if (phase_q == adc_seq_pkg::ph_signal &&
          count_q == adc_seq_pkg::signal_counts -
          adc_seq_pkg::count_one) begin
        count_q <= adc_seq_pkg::count_zero;
      end else begin
        count_q <= count_q + adc_seq_pkg::count_one;
      end
      total_q <= total_q + adc_seq_pkg::count_one;
    end
  end

  // Decimal reference-phase counter; this count is the reading
  logic [4:0] u_inc;
  logic [4:0] t_inc;
  logic [4:0] h_inc;
  logic cnt_en;
  assign cnt_en = (phase_q == adc_seq_pkg::ph_reference) && tick && !done;
  assign u_inc = bcd_inc(bcd_q[0], cnt_en);
  assign t_inc = bcd_inc(bcd_q[1], u_inc[4]);
  assign h_inc = bcd_inc(bcd_q[2], t_inc[4]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcd_q[0] <= adc_seq_pkg::bcd_zero;
      bcd_q[1] <= adc_seq_pkg::bcd_zero;
      bcd_q[2] <= adc_seq_pkg::bcd_zero;
      thou_q <= 1'b0;
    end else if (start_rise) begin
      bcd_q[0] <= adc_seq_pkg::bcd_zero;
      bcd_q[1] <= adc_seq_pkg::bcd_zero;
      bcd_q[2] <= adc_seq_pkg::bcd_zero;
      thou_q <= 1'b0;
    end else begin
      bcd_q[0] <= u_inc[3:0];
      bcd_q[1] <= t_inc[3:0];
      bcd_q[2] <= h_inc[3:0];
      thou_q <= thou_q | h_inc[4];
    end
  end

  // ********************************************************************
  // Output latches
  // ********************************************************************
  logic [15:0] latch_d;
  logic [15:0] latch_q;
  logic latch_load;
  // Overrange loads too, so its flag is latched; thousands inverted
  assign latch_load = done || overflow;
  assign latch_d = {1'b0, !overflow, sign_q, !thou_q,
                    bcd_q[2], bcd_q[1], bcd_q[0]};

  adc_seq_latch u_latch (
    .pclk(pclk),
    .presetn(presetn),
    .load(latch_load),
    .wdata(latch_d),
    .rdata(latch_q)
  );

  // Output pins mirror the latch through one flop each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      digits <= 12'h000;
      thou_n <= 1'b1;
      sign_out <= 1'b0;
      overrange_flag_n <= 1'b1;
    end else begin
      digits <= latch_q[11:0];
      thou_n <= latch_q[adc_seq_pkg::res_thou_n_bit];
      sign_out <= latch_q[adc_seq_pkg::res_sign_bit];
      overrange_flag_n <= latch_q[adc_seq_pkg::res_over_n_bit];
    end
  end

  // Switch, status and gated clock outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_input <= 1'b0;
      sw_ref_pos <= 1'b0;
      sw_ref_neg <= 1'b0;
      sw_autozero <= 1'b1;
      busy <= 1'b0;
      ref_phase <= 1'b0;
      gated_clk <= 1'b0;
    end else begin
      sw_input <= phase_q == adc_seq_pkg::ph_signal;
      // Positive input ramps back with the negative reference
      sw_ref_pos <= phase_q == adc_seq_pkg::ph_reference &&
                    !sign_q;
      sw_ref_neg <= phase_q == adc_seq_pkg::ph_reference &&
                    sign_q;
      sw_autozero <= phase_q == adc_seq_pkg::ph_autozero;
      busy <= phase_q != adc_seq_pkg::ph_autozero;
      ref_phase <= phase_q == adc_seq_pkg::ph_reference;
      // Follows the synced clock while measuring, low otherwise
      gated_clk <= cclk_s &&
                   phase_q != adc_seq_pkg::ph_autozero;
    end
  end

  // ********************************************************************
  // Read path
  // ********************************************************************
  // Read mux, one registered word; unmapped reads zero with error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        if (paddr == adc_seq_pkg::ctrl_addr) begin
          prdata[adc_seq_pkg::ctrl_start_bit] <= start_reg_q;
          prdata[adc_seq_pkg::ctrl_override_bit] <= override_reg_q;
        end else if (paddr == adc_seq_pkg::status_addr) begin
          prdata[adc_seq_pkg::st_busy_bit] <= busy;
          prdata[adc_seq_pkg::st_ref_bit] <= ref_phase;
          prdata[adc_seq_pkg::st_sign_bit] <= sign_out;
          prdata[adc_seq_pkg::st_over_n_bit] <= overrange_flag_n;
          prdata[adc_seq_pkg::st_thou_n_bit] <= thou_n;
        end else if (paddr == adc_seq_pkg::result_addr) begin
          prdata[15:0] <= latch_q;
        end else if (paddr == adc_seq_pkg::count_addr) begin
          prdata[11:0] <= total_q;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  logic unused_rd;
  assign unused_rd = rd_en;

endmodule

//--- adc_seq_top_assertions.sv
// Checker of the sequencer's phase, latch and clock-gating relations
module adc_seq_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic conv_clk,
  input wire logic start_pin,
  input wire logic override_pin,
  input wire logic ext_count_pin,
  input wire logic sw_input,
  input wire logic sw_ref_pos,
  input wire logic sw_ref_neg,
  input wire logic sw_autozero,
  input wire logic busy,
  input wire logic ref_phase,
  input wire logic gated_clk,
  input wire logic sign_out,
  input wire logic overrange_flag_n,
  input wire logic thou_n,
  input wire logic [11:0] digits
);
  // ********************
  // Tick counting
  // ********************
  logic conv_q; // Converter clock one pclk ago
  logic [11:0] ticks_q; // Converter rises seen while busy
  // Edge memory for the converter clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_q <= 1'b0;
    end else begin
      conv_q <= conv_clk;
    end
  end
  // Cleared when idle so each measurement is judged alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ticks_q <= 12'h000;
    end else if (!busy) begin
      ticks_q <= 12'h000;
    end else if (conv_clk && !conv_q) begin
      ticks_q <= ticks_q + 12'h001;
    end
  end
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ref_only_a: assert property (ref_phase |-> busy && !sw_input)
    else $error("reference flag outside reference phase");
  ref_pick_a: assert property (ref_phase |-> sw_ref_pos ^ sw_ref_neg)
    else $error("not exactly one reference switch");
  sig_phase_a: assert property (sw_input |-> busy && !sw_autozero)
    else $error("input switch closed while idle");
  start_busy_a: assert property (
    $rose(start_pin) && !busy |-> ##[1:6] busy)
    else $error("busy did not follow start");
  gclk_off_a: assert property (sw_autozero [*3] |-> !gated_clk)
    else $error("gated clock runs in auto-zero");
  gclk_run_a: assert property (sw_input [*6] |-> ##[0:4] gated_clk)
    else $error("gated clock stopped in measurement");
  latch_idle_a: assert property (
    (!busy) [*4] |=> $stable({digits, thou_n, sign_out, overrange_flag_n}))
    else $error("latched outputs moved while idle");
  carry_cut_a: assert property (
    (override_pin && !ext_count_pin) [*8] |=> !$rose(ref_phase))
    else $error("reference began under override");
  over_end_a: assert property (
    $fell(overrange_flag_n) |-> ##[0:3] !busy)
    else $error("overrange did not end conversion");
  cycle_cap_a: assert property (ticks_q <= 12'hBBB)
    else $error("measurement too long");
endmodule

//--- adc_seq_top_tb.sv
// Self-checking bench of the converter sequencer with front-end model
module adc_seq_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic start_pin = 1'b0, override_pin = 1'b0, ext_count_pin = 1'b0;
  logic conv_clk, comp_pos, sw_input, sw_ref_pos, sw_ref_neg;
  logic sw_autozero, busy, ref_phase, gated_clk, sign_out;
  logic overrange_flag_n, thou_n;
  logic [11:0] digits;
  int vin = 0; // Analog input in counts
  int err_total = 0;
  int n_tests = 0;
  adc_seq_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .conv_clk, .start_pin,
    .override_pin, .ext_count_pin, .comp_pos, .sw_input, .sw_ref_pos,
    .sw_ref_neg, .sw_autozero, .busy, .ref_phase, .gated_clk, .sign_out,
    .overrange_flag_n, .thou_n, .digits);
  adc_front_model fe (.pclk, .sw_input, .sw_ref_pos, .sw_ref_neg,
    .sw_autozero, .vin, .conv_clk, .comp_pos);
  always #25 pclk = ~pclk;
  task automatic final_report();
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic bad(input string m);
    err_total++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp_bit(input logic g, input logic e, input string m);
    n_tests++;
    if (g !== e) bad(m);
  endtask
  // Two counts of slack: tick and comparator cross a synchroniser
  task automatic cmp_cnt(input logic [15:0] b, input int x, input string m);
    int g;
    g = b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0];
    n_tests++;
    if ($isunknown(b) || g < x - 2 || g > x + 2) bad(m);
  endtask
  // Binary count within a window of accepted values
  task automatic cmp_num(input logic [31:0] g, input int lo, input int hi,
    input string m);
    n_tests++;
    if ($isunknown(g) || g < lo || g > hi) bad(m);
  endtask
  // Bounded wait on busy (k=0) or reference phase (k=1)
  task automatic wait_on(input int k, input logic v);
    int n;
    n = 0;
    while ((k ? ref_phase : busy) !== v && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    cmp_bit(k ? ref_phase : busy, v, "wait ran out");
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cmp_bit(pready, 1'b1, "no ready");
  endtask
  task automatic start_conv();
    @(negedge conv_clk);
    @(posedge pclk);
    start_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    start_pin <= 1'b0;
  endtask
  task automatic ext_pulse();
    ext_count_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    ext_count_pin <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask
  task automatic t_reset();
    // Second edge shows what the first edge after release produced
    repeat (2) @(posedge pclk);
    cmp_bit(sw_autozero, 1'b1, "auto-zero at reset");
    cmp_bit(overrange_flag_n, 1'b1, "overrange at reset");
    cmp_bit(thou_n, 1'b1, "thousands at reset");
    cmp_bit(sign_out, 1'b0, "sign at reset");
    cmp_bit(busy, 1'b0, "busy at reset");
    cmp_bit(gated_clk, 1'b0, "gated clock at reset");
  endtask
  // Both polarities, thousands digit, full scale and overrange
  task automatic t_table();
    int tv[5] = '{5, -123, 1500, -1999, 2500};
    for (int i = 0; i < 5; i++) begin
      vin = tv[i];
      start_conv();
      wait_on(0, 1'b1);
      repeat (500) @(posedge conv_clk);
      ext_pulse();
      cmp_bit(ref_phase, 1'b0, "count pulse taken");
      wait_on(1, 1'b1);
      cmp_bit(sw_ref_neg, vin > 0, "negative switch");
      cmp_bit(sw_ref_pos, vin < 0, "positive switch");
      wait_on(0, 1'b0);
      repeat (3) @(posedge pclk);
      cmp_bit(sw_autozero, 1'b1, "no auto-zero");
      cmp_bit(overrange_flag_n, vin < 2000, "overrange");
      if (vin < 2000) begin
        cmp_bit(sign_out, vin > 0, "sign");
        cmp_cnt({3'b000, ~thou_n, digits}, vin < 0 ? -vin : vin,
          "reading");
      end
    end
  endtask
  // Gain stretched by holding the override past the first carry
  task automatic t_gain();
    vin = 500;
    override_pin <= 1'b1;
    start_conv();
    wait_on(0, 1'b1);
    repeat (1200) @(posedge conv_clk);
    cmp_bit(ref_phase, 1'b0, "carry not held off");
    cmp_bit(sw_input, 1'b1, "signal phase left");
    cmp_bit(overrange_flag_n, 1'b0, "latch not held");
    // Gated clock trails the converter clock through the synchroniser
    @(posedge conv_clk);
    repeat (4) @(posedge pclk);
    cmp_bit(gated_clk, 1'b1, "gated clock low in measure");
    repeat (2) @(posedge pclk);
    cmp_bit(gated_clk, 1'b0, "gated clock stuck high");
    repeat (300) @(posedge conv_clk);
    ext_pulse();
    cmp_bit(ref_phase, 1'b1, "count pulse ignored");
    override_pin <= 1'b0;
    wait_on(0, 1'b0);
    repeat (3) @(posedge pclk);
    cmp_cnt({3'b000, ~thou_n, digits}, 750, "stretched reading");
  endtask
  // Start by register, status while busy, result and a hole
  task automatic t_apb();
    logic [31:0] r;
    logic e;
    vin = -42;
    apb(1'b1, adc_seq_pkg::ctrl_addr, 32'h0000_0003, r, e);
    apb(1'b0, adc_seq_pkg::ctrl_addr, 32'h0000_0000, r, e);
    cmp_bit(r[adc_seq_pkg::ctrl_start_bit], 1'b1, "start bit");
    cmp_bit(r[adc_seq_pkg::ctrl_override_bit], 1'b1, "override");
    apb(1'b1, adc_seq_pkg::ctrl_addr, 32'h0000_0000, r, e);
    apb(1'b0, adc_seq_pkg::status_addr, 32'h0000_0000, r, e);
    cmp_bit(r[adc_seq_pkg::st_busy_bit], 1'b1, "status busy");
    cmp_bit(r[adc_seq_pkg::st_ref_bit], 1'b0, "status ref");
    cmp_bit(e, 1'b0, "status error");
    wait_on(0, 1'b0);
    apb(1'b0, adc_seq_pkg::result_addr, 32'h0000_0000, r, e);
    cmp_cnt({3'b000, ~r[adc_seq_pkg::res_thou_n_bit], r[11:0]}, 42,
      "result word");
    cmp_bit(r[adc_seq_pkg::res_sign_bit], 1'b0, "result sign");
    cmp_bit(r[adc_seq_pkg::res_over_n_bit], 1'b1, "result over");
    // 1000 signal clocks plus about 42 reference clocks
    apb(1'b0, adc_seq_pkg::count_addr, 32'h0000_0000, r, e);
    cmp_num(r, 1040, 1045, "clock total");
    apb(1'b0, 8'h10, 32'h0000_0000, r, e);
    cmp_bit(e, 1'b1, "hole accepted");
    cmp_bit(|r, 1'b0, "hole data");
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_table();
    t_gain();
    t_apb();
    final_report();
  end
  // Watchdog well past the longest expected run
  initial begin
    repeat (99000) @(posedge pclk);
    err_total++;
    final_report();
  end
endmodule
bind adc_seq_top adc_seq_checker chk (.pclk, .presetn, .conv_clk,
  .start_pin, .override_pin, .ext_count_pin, .sw_input, .sw_ref_pos,
  .sw_ref_neg, .sw_autozero, .busy, .ref_phase, .gated_clk, .sign_out,
  .overrange_flag_n, .thou_n, .digits);
